// file: logic/rieec_regs.vh
`ifndef RIEEC_REGS_VH
`define RIEEC_REGS_VH
`define RIEEC_ADR_PINFN 16'hffeb
`define RIEEC_ADR_EDGE 16'hfff2
`define RIEEC_ADR_ENA 16'hfff3
`define RIEEC_ADR_ENB 16'hfff4
`define RIEEC_ADR_ENC 16'hfff5
`define RIEEC_ADR_FLA 16'hfff6
`define RIEEC_ADR_FLB 16'hfff7
`define RIEEC_ADR_FLC 16'hfff8
`define RIEEC_RST_PINFN 8'h0c
`define RIEEC_RST_EDGE 8'hec
`define RIEEC_RST_ENA 8'hc0
`define RIEEC_RST_ENB 8'h00
`define RIEEC_RST_ENC 8'h3c
`define RIEEC_RST_FLA 8'hc0
`define RIEEC_RST_FLB 8'h00
`define RIEEC_RST_FLC 8'h3c
// Writable bits per register; the rest hold their reset value
`define RIEEC_WM_PINFN 8'hf3
`define RIEEC_WM_EDGE 8'h13
`define RIEEC_WM_ENA 8'h3f
`define RIEEC_WM_ENB 8'hff
`define RIEEC_WM_ENC 8'hc3
// Flag bit positions within the three flag registers
`define RIEEC_B_EXT_INT_LINE_0 0
`define RIEEC_B_EXT_INT_LINE_1 1
`define RIEEC_B_EXT_INT_LINE_4 4
`define RIEEC_B_EXT_INT_LINE_5 5
`define RIEEC_B_DT 0
`define RIEEC_B_SER1 6
`define RIEEC_B_SER2 7
`define RIEEC_B_ADC 1
`define RIEEC_VEC_RESET 16'h0000
`define RIEEC_VEC_EXT_INT_LINE_0 16'h0008
`define RIEEC_VEC_EXT_INT_LINE_1 16'h000a
`define RIEEC_VEC_EXT_INT_LINE_4 16'h0010
`define RIEEC_VEC_EXT_INT_LINE_5 16'h0012
`define RIEEC_VEC_KEY 16'h0014
`define RIEEC_VEC_TMA 16'h0016
`define RIEEC_VEC_TMB 16'h0018
`define RIEEC_VEC_TMC 16'h001a
`define RIEEC_VEC_TMD 16'h001c
`define RIEEC_VEC_TME 16'h001e
`define RIEEC_VEC_DT 16'h0020
`define RIEEC_VEC_SER1 16'h0026
`define RIEEC_VEC_SER2 16'h0028
`define RIEEC_VEC_ADC 16'h002a
`define RIEEC_DT_DELAY 16'h0100
`endif

// file: logic/rieec_edge.v
`timescale 1ns/1ps
// Edge detector for one external interrupt line
module rieec_edge (
	input wire clk,
	input wire rst,
	input wire pin,
	input wire en,
	input wire rise_sel,
	output wire hit
);
	reg prev_q;

	// Previous level of the pin
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= pin;
		end
	end

	// Selected edge while the pin has its interrupt function
	assign hit = en & (rise_sel ? (pin & ~prev_q) : (~pin & prev_q));
endmodule // rieec_edge

// file: logic/rieec_dtimer.v
`timescale 1ns/1ps
`include "rieec_regs.vh"
// Delay from sleep execution to the direct transfer request
module rieec_dtimer #(
	parameter DELAY = `RIEEC_DT_DELAY
) (
	input wire clk,
	input wire rst,
	input wire sleep_exec,
	output reg fire
);
	reg [15:0] cnt_q;
	reg armed_q;

	// Armed by sleep, one-cycle pulse after DELAY clocks
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			armed_q <= 1'b0;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			if (sleep_exec) begin
				armed_q <= 1'b1;
				cnt_q <= 16'h0000;
			end else if (armed_q) begin
				if (cnt_q == DELAY[15:0] - 16'h0001) begin
					armed_q <= 1'b0;
					fire <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule // rieec_dtimer

// file: logic/rieec_ctrl.v
`timescale 1ns/1ps
`include "rieec_regs.vh"
// Reset sequencing, interrupt flags, priority and vectors
module rieec_ctrl #(
	parameter DT_DELAY = `RIEEC_DT_DELAY
) (
	input wire clk,
	input wire rst,
	input wire chip_reset_pin_n,
	input wire ext_int_line_0,
	input wire ext_int_line_1,
	input wire ext_int_line_4,
	input wire ext_int_line_5,
	input wire key_scan_req,
	input wire [4:0] timer_ovf_req,
	input wire serial_channel_one_req,
	input wire serial_channel_two_req,
	input wire adc_end_req,
	input wire sleep_exec,
	input wire insn_done,
	input wire mask_set,
	input wire mask_clear,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_hit,
	output wire cpu_halt,
	output wire periph_init,
	output reg global_mask,
	output reg exc_start,
	output reg exc_is_reset,
	output reg [15:0] vector_addr,
	output reg push_state
);
	// One-hot sequencer states
	localparam S_RESET = 3'b001;
	localparam S_RUN = 3'b010;
	localparam S_WAIT = 3'b100;

	// Sequencer state, control registers and request flags
	reg [2:0] state_q;
	reg [7:0] pinfn_q;
	reg [7:0] edge_q;
	reg [7:0] ena_q;
	reg [7:0] enb_q;
	reg [7:0] enc_q;
	reg [7:0] fla_q;
	reg [7:0] flb_q;
	reg [7:0] flc_q;
	reg [7:0] fla_d;
	reg [7:0] flb_d;
	reg [7:0] flc_d;
	reg [7:0] set_a;
	reg [7:0] set_b;
	reg [7:0] set_c;
	reg rst_pend_q;
	reg pend;
	reg [15:0] vec;
	reg [7:0] nxt;
	wire hit0;
	wire hit1;
	wire hit4;
	wire hit5;
	wire dt_fire;
	wire [7:0] act_a;
	wire [7:0] act_b;
	wire [7:0] act_c;

	// Merge writable bits with the fixed reserved bits
	function [7:0] merge;
		input [7:0] wd;
		input [7:0] wm;
		input [7:0] rv;
		begin
			merge = (wd & wm) | (rv & ~wm);
		end
	endfunction

	// Reset pin low halts the core and clears peripheral registers
	assign cpu_halt = ~chip_reset_pin_n | state_q[0];
	assign periph_init = ~chip_reset_pin_n;

	// Edge detectors, one per external line
	rieec_edge u_e0 (
		.clk(clk),
		.rst(rst),
		.pin(ext_int_line_0),
		.en(pinfn_q[0]),
		.rise_sel(edge_q[0]),
		.hit(hit0)
	);
	rieec_edge u_e1 (
		.clk(clk),
		.rst(rst),
		.pin(ext_int_line_1),
		.en(pinfn_q[1]),
		.rise_sel(edge_q[1]),
		.hit(hit1)
	);
	rieec_edge u_e4 (
		.clk(clk),
		.rst(rst),
		.pin(ext_int_line_4),
		.en(pinfn_q[4]),
		.rise_sel(edge_q[4]),
		.hit(hit4)
	);
	rieec_edge u_e5 (
		.clk(clk),
		.rst(rst),
		.pin(ext_int_line_5),
		.en(pinfn_q[5]),
		.rise_sel(1'b0),
		.hit(hit5)
	);
	// Direct transfer delay from sleep to request
	rieec_dtimer #(
		.DELAY(DT_DELAY)
	) u_dt (
		.clk(clk),
		.rst(rst),
		.sleep_exec(sleep_exec),
		.fire(dt_fire)
	);

	// Event sets for each flag register
	always @* begin
		set_a = 8'h00;
		set_b = 8'h00;
		set_c = 8'h00;
		set_a[`RIEEC_B_EXT_INT_LINE_0] = hit0;
		set_a[`RIEEC_B_EXT_INT_LINE_1] = hit1;
		set_a[`RIEEC_B_EXT_INT_LINE_4] = hit4;
		set_a[`RIEEC_B_EXT_INT_LINE_5] = hit5;
		set_b = {key_scan_req, timer_ovf_req, 2'b00};
		set_c[`RIEEC_B_DT] = dt_fire;
		set_c[`RIEEC_B_ADC] = adc_end_req;
		set_c[`RIEEC_B_SER1] = serial_channel_one_req;
		set_c[`RIEEC_B_SER2] = serial_channel_two_req;
	end

	// Write 0 clears, write 1 keeps, a new event wins over the clear
	always @* begin
		fla_d = fla_q;
		flb_d = flb_q;
		flc_d = flc_q;
		if (reg_wr && reg_addr == `RIEEC_ADR_FLA) begin
			fla_d = fla_q & (reg_wdata | ~`RIEEC_WM_ENA);
		end else if (reg_wr && reg_addr == `RIEEC_ADR_FLB) begin
			flb_d = flb_q & (reg_wdata | ~`RIEEC_WM_ENB);
		end else if (reg_wr && reg_addr == `RIEEC_ADR_FLC) begin
			flc_d = flc_q & (reg_wdata | ~`RIEEC_WM_ENC);
		end
		fla_d = fla_d | set_a;
		flb_d = flb_d | set_b;
		flc_d = flc_d | set_c;
	end

	// Requests that are both flagged and enabled
	assign act_a = fla_q & ena_q & `RIEEC_WM_ENA;
	assign act_b = flb_q & enb_q;
	assign act_c = flc_q & enc_q & `RIEEC_WM_ENC;

	// Fixed priority; reserved slots have no source and no vector
	always @* begin
		pend = 1'b1;
		vec = `RIEEC_VEC_ADC;
		if (act_a[`RIEEC_B_EXT_INT_LINE_0]) begin
			vec = `RIEEC_VEC_EXT_INT_LINE_0;
		end else if (act_a[`RIEEC_B_EXT_INT_LINE_1]) begin
			vec = `RIEEC_VEC_EXT_INT_LINE_1;
		end else if (act_a[`RIEEC_B_EXT_INT_LINE_4]) begin
			vec = `RIEEC_VEC_EXT_INT_LINE_4;
		end else if (act_a[`RIEEC_B_EXT_INT_LINE_5]) begin
			vec = `RIEEC_VEC_EXT_INT_LINE_5;
		end else if (act_b[7]) begin
			vec = `RIEEC_VEC_KEY;
		end else if (act_b[6]) begin
			vec = `RIEEC_VEC_TMA;
		end else if (act_b[5]) begin
			vec = `RIEEC_VEC_TMB;
		end else if (act_b[4]) begin
			vec = `RIEEC_VEC_TMC;
		end else if (act_b[3]) begin
			vec = `RIEEC_VEC_TMD;
		end else if (act_b[2]) begin
			vec = `RIEEC_VEC_TME;
		end else if (act_c[`RIEEC_B_DT]) begin
			vec = `RIEEC_VEC_DT;
		end else if (act_c[`RIEEC_B_SER1]) begin
			vec = `RIEEC_VEC_SER1;
		end else if (act_c[`RIEEC_B_SER2]) begin
			vec = `RIEEC_VEC_SER2;
		end else if (act_c[`RIEEC_B_ADC]) begin
			vec = `RIEEC_VEC_ADC;
		end else begin
			pend = 1'b0;
		end
	end

	// Next-state for the exception sequencer
	always @* begin
		nxt = {5'b00000, state_q};
		case (state_q)
		S_RESET: begin
			if (chip_reset_pin_n) begin
				nxt = {5'b00000, S_RUN};
			end
		end
		S_RUN: begin
			if (pend && !global_mask) begin
				nxt = {5'b00000, S_WAIT};
			end
		end
		S_WAIT: begin
			if (insn_done) begin
				nxt = {5'b00000, S_RUN};
			end
		end
		default: begin
			nxt = {5'b00000, S_RESET};
		end
		endcase
		if (!chip_reset_pin_n) begin
			nxt = {5'b00000, S_RESET};
		end
	end

	// Sequencer, mask bit and exception outputs
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_RESET;
			global_mask <= 1'b1;
			exc_start <= 1'b0;
			exc_is_reset <= 1'b0;
			vector_addr <= `RIEEC_VEC_RESET;
			push_state <= 1'b0;
			rst_pend_q <= 1'b1;
		end else begin
			state_q <= nxt[2:0];
			exc_start <= 1'b0;
			exc_is_reset <= 1'b0;
			push_state <= 1'b0;
			// Mask checked again at acceptance; mask_set may land in the wait
			if (!chip_reset_pin_n) begin
				global_mask <= 1'b1;
				rst_pend_q <= 1'b1;
			end else if (state_q[0]) begin
				exc_start <= 1'b1;
				exc_is_reset <= 1'b1;
				vector_addr <= `RIEEC_VEC_RESET;
				rst_pend_q <= 1'b0;
			end else if (state_q[2] && insn_done && pend &&
				!global_mask) begin
				exc_start <= 1'b1;
				push_state <= 1'b1;
				vector_addr <= vec;
				global_mask <= 1'b1;
			end else if (mask_set) begin
				global_mask <= 1'b1;
			end else if (mask_clear && !rst_pend_q) begin
				global_mask <= 1'b0;
			end
		end
	end

	// Control registers and flags; reset pin low reinitialises them
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pinfn_q <= `RIEEC_RST_PINFN;
			edge_q <= `RIEEC_RST_EDGE;
			ena_q <= `RIEEC_RST_ENA;
			enb_q <= `RIEEC_RST_ENB;
			enc_q <= `RIEEC_RST_ENC;
			fla_q <= `RIEEC_RST_FLA;
			flb_q <= `RIEEC_RST_FLB;
			flc_q <= `RIEEC_RST_FLC;
		end else if (!chip_reset_pin_n) begin
			pinfn_q <= `RIEEC_RST_PINFN;
			edge_q <= `RIEEC_RST_EDGE;
			ena_q <= `RIEEC_RST_ENA;
			enb_q <= `RIEEC_RST_ENB;
			enc_q <= `RIEEC_RST_ENC;
			fla_q <= `RIEEC_RST_FLA;
			flb_q <= `RIEEC_RST_FLB;
			flc_q <= `RIEEC_RST_FLC;
		end else begin
			fla_q <= fla_d;
			flb_q <= flb_d;
			flc_q <= flc_d;
			if (reg_wr && reg_addr == `RIEEC_ADR_PINFN) begin
				pinfn_q <= merge(reg_wdata, `RIEEC_WM_PINFN,
					`RIEEC_RST_PINFN);
			end else if (reg_wr && reg_addr == `RIEEC_ADR_EDGE) begin
				edge_q <= merge(reg_wdata, `RIEEC_WM_EDGE,
					`RIEEC_RST_EDGE);
			end else if (reg_wr && reg_addr == `RIEEC_ADR_ENA) begin
				ena_q <= merge(reg_wdata, `RIEEC_WM_ENA,
					`RIEEC_RST_ENA);
			end else if (reg_wr && reg_addr == `RIEEC_ADR_ENB) begin
				enb_q <= reg_wdata;
			end else if (reg_wr && reg_addr == `RIEEC_ADR_ENC) begin
				enc_q <= merge(reg_wdata, `RIEEC_WM_ENC,
					`RIEEC_RST_ENC);
			end
		end
	end

	// Registered read data; unmapped addresses read zero with no hit
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else begin
			reg_hit <= reg_rd;
			if (!reg_rd) begin
				reg_rdata <= 8'h00;
				reg_hit <= 1'b0;
			end else if (reg_addr == `RIEEC_ADR_PINFN) begin
				reg_rdata <= pinfn_q;
			end else if (reg_addr == `RIEEC_ADR_EDGE) begin
				reg_rdata <= edge_q;
			end else if (reg_addr == `RIEEC_ADR_ENA) begin
				reg_rdata <= ena_q;
			end else if (reg_addr == `RIEEC_ADR_ENB) begin
				reg_rdata <= enb_q;
			end else if (reg_addr == `RIEEC_ADR_ENC) begin
				reg_rdata <= enc_q;
			end else if (reg_addr == `RIEEC_ADR_FLA) begin
				reg_rdata <= fla_q;
			end else if (reg_addr == `RIEEC_ADR_FLB) begin
				reg_rdata <= flb_q;
			end else if (reg_addr == `RIEEC_ADR_FLC) begin
				reg_rdata <= flc_q;
			end else begin
				reg_rdata <= 8'h00;
				reg_hit <= 1'b0;
			end
		end
	end
endmodule // rieec_ctrl

// file: test/rieec_ctrl_sva.sv
`timescale 1ns/1ps
// Checks reset sequencing, acceptance and vectors at the ports
module rieec_ctrl_sva #(
	parameter DT_DELAY = 16'h0100
) (
	input wire clk,
	input wire rst,
	input wire chip_reset_pin_n,
	input wire insn_done,
	input wire cpu_halt,
	input wire periph_init,
	input wire global_mask,
	input wire exc_start,
	input wire exc_is_reset,
	input wire [15:0] vector_addr,
	input wire push_state
);
	// Interrupt exception, as opposed to reset
	wire irq_x = exc_start && !exc_is_reset;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Pin low halts, masks and blocks exceptions
	pin_halt_a: assert property (
		!chip_reset_pin_n |-> cpu_halt && periph_init)
		else $error("halt missing while pin low");
	pin_mask_a: assert property (
		!chip_reset_pin_n |=> global_mask)
		else $error("mask not set by pin");
	pin_block_a: assert property (
		!chip_reset_pin_n |=> !exc_start)
		else $error("exception while pin low");
	// Reset handling starts on the rising pin
	rst_start_a: assert property (
		$rose(chip_reset_pin_n) |-> ##[1:2] exc_is_reset)
		else $error("reset handling late");
	rst_vec_a: assert property (
		exc_is_reset |-> exc_start && vector_addr == 16'h0000)
		else $error("bad reset vector");
	// Interrupt acceptance needs completion and a clear mask
	irq_wait_a: assert property (
		irq_x |-> $past(insn_done))
		else $error("interrupt before instruction end");
	irq_mask_a: assert property (
		irq_x |-> !$past(global_mask) && global_mask && push_state)
		else $error("interrupt taken while masked");
	vec_ok_a: assert property (
		exc_start |-> !vector_addr[0] && vector_addr <= 16'h002a &&
		!(vector_addr inside {16'h0002, 16'h0004, 16'h0006, 16'h000c,
		16'h000e, 16'h0022, 16'h0024}))
		else $error("vector outside table");
	// Main scenarios
	cover property (exc_is_reset);
	cover property (irq_x && vector_addr == 16'h0020);
	cover property (irq_x ##[1:20] irq_x);
endmodule // rieec_ctrl_sva

bind rieec_ctrl rieec_ctrl_sva #(.DT_DELAY(DT_DELAY)) i_rieec_ctrl_sva (
	.clk, .rst, .chip_reset_pin_n, .insn_done, .cpu_halt, .periph_init,
	.global_mask, .exc_start, .exc_is_reset, .vector_addr, .push_state);

// file: test/rieec_cpu_model.sv
`timescale 1ns/1ps
// CPU core side: instruction completion and an outside reset source
module rieec_cpu_model (
	input wire clk,
	input wire slow,
	input wire do_reset,
	output reg insn_done,
	output reg chip_reset_pin_n
);
	reg [1:0] cnt_q = 2'h0;
	initial begin
		insn_done = 1'b0;
		chip_reset_pin_n = 1'b1;
	end
	// Instructions end every cycle, or every fourth one when slow
	always @(negedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		insn_done <= slow ? (cnt_q == 2'h3) : 1'b1;
	end
	// Outside reset holds the pin low for ten clocks
	always @(posedge do_reset) begin
		@(negedge clk) chip_reset_pin_n <= 1'b0;
		repeat (10) @(negedge clk);
		chip_reset_pin_n <= 1'b1;
	end
endmodule // rieec_cpu_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, slow = 0, do_reset = 0, mask_set = 0;
	logic ext_int_line_0 = 1, ext_int_line_1 = 1;
	logic ext_int_line_4 = 1, ext_int_line_5 = 1;
	logic key_scan_req = 0, serial_channel_one_req = 0, adc_end_req = 0;
	logic serial_channel_two_req = 0, sleep_exec = 0, mask_clear = 0;
	logic reg_wr = 0, reg_rd = 0;
	logic [4:0] timer_ovf_req = 0;
	logic [15:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	wire insn_done, chip_reset_pin_n, reg_hit, cpu_halt, periph_init;
	wire global_mask, exc_start, exc_is_reset, push_state;
	wire [7:0] reg_rdata;
	wire [15:0] vector_addr;
	int error_cnt = 0, n_checks = 0;
	logic [13:0] pend;
	localparam logic [15:0] RA [8] = '{16'hffeb, 16'hfff2, 16'hfff3,
		16'hfff4, 16'hfff5, 16'hfff6, 16'hfff7, 16'hfff8};
	localparam logic [7:0] RV [8] = '{8'h0c, 8'hec, 8'hc0, 8'h00, 8'h3c,
		8'hc0, 8'h00, 8'h3c};
	localparam logic [7:0] WM [8] = '{8'hf3, 8'h13, 8'h3f, 8'hff, 8'hc3,
		8'h00, 8'h00, 8'h00};
	localparam logic [15:0] VT [14] = '{16'h0008, 16'h000a, 16'h0010,
		16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
		16'h001e, 16'h0020, 16'h0026, 16'h0028, 16'h002a};
	localparam int BT [14] = '{0, 1, 4, 5, 7, 6, 5, 4, 3, 2, 0, 6, 7, 1};
	rieec_ctrl #(
		.DT_DELAY(4)
	) i_rieec_ctrl (
		.clk(clk),
		.rst(rst),
		.chip_reset_pin_n(chip_reset_pin_n),
		.ext_int_line_0(ext_int_line_0),
		.ext_int_line_1(ext_int_line_1),
		.ext_int_line_4(ext_int_line_4),
		.ext_int_line_5(ext_int_line_5),
		.key_scan_req(key_scan_req),
		.timer_ovf_req(timer_ovf_req),
		.serial_channel_one_req(serial_channel_one_req),
		.serial_channel_two_req(serial_channel_two_req),
		.adc_end_req(adc_end_req),
		.sleep_exec(sleep_exec),
		.insn_done(insn_done),
		.mask_set(mask_set),
		.mask_clear(mask_clear),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_hit(reg_hit),
		.cpu_halt(cpu_halt),
		.periph_init(periph_init),
		.global_mask(global_mask),
		.exc_start(exc_start),
		.exc_is_reset(exc_is_reset),
		.vector_addr(vector_addr),
		.push_state(push_state)
	);
	rieec_cpu_model i_rieec_cpu_model (
		.clk(clk),
		.slow(slow),
		.do_reset(do_reset),
		.insn_done(insn_done),
		.chip_reset_pin_n(chip_reset_pin_n)
	);
	// Clock
	initial begin
		forever #50 clk = ~clk;
	end
	task chk(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("Checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk);
		reg_rd = 0;
		chk("rdata", reg_rdata, e);
		chk("hit", reg_hit, a inside {RA});
	endtask
	task set_lines(input logic [3:0] v);
		{ext_int_line_5, ext_int_line_4, ext_int_line_1, ext_int_line_0} = v;
	endtask
	task unmask;
		@(negedge clk);
		mask_clear = 1;
		@(negedge clk);
		mask_clear = 0;
	endtask
	task wait_exc(input logic [15:0] e, input logic r);
		int i;
		for (i = 0; i < 60 && exc_start !== 1'b1; i++)
			@(negedge clk);
		chk("exc_start", exc_start, 1);
		chk("vector", vector_addr, e);
		chk("is_reset", exc_is_reset, r);
	endtask
	// Watchdog against a hang
	initial begin
		#3000000;
		error_cnt++;
		test_done;
	end
	// Main sequence
	initial begin
		int s, i, k, r;
		r = $urandom(84);
		repeat (2) @(negedge clk);
		rst = 0;
		wait_exc(16'h0000, 1);
		chk("mask", global_mask, 1);
		for (i = 0; i < 8; i++) begin
			rd(RA[i], RV[i]);
			wr(RA[i], 8'h00);
			rd(RA[i], RV[i] & ~WM[i]);
			wr(RA[i], 8'hff);
			rd(RA[i], RV[i] | WM[i]);
		end
		rd(16'hfff9, 8'h00);
		chk("hit", reg_hit, 0);
		wr(16'hffeb, 8'h33);
		// Edge polarity per line while masked
		for (s = 0; s < 2; s++) begin
			wr(16'hfff2, s ? 8'hff : 8'h00);
			set_lines(s ? 4'h0 : 4'hf);
			repeat (3) @(negedge clk);
			wr(16'hfff6, 8'h00);
			set_lines(s ? 4'hf : 4'h0);
			repeat (3) @(negedge clk);
			rd(16'hfff6, s ? 8'hd3 : 8'hf3);
		end
		wr(16'hfff6, 8'hef);
		rd(16'hfff6, 8'hc3);
		wr(16'hfff6, 8'h00);
		wr(16'hfff2, 8'h00);
		// Random request sets, serviced in priority order
		for (k = 0; k < 16; k++) begin
			r = (k == 0) ? 14'h3fff : $urandom;
			pend = (r[13:0] == 0) ? 14'h0400 : r[13:0];
			slow = k[0];
			@(negedge clk);
			set_lines(~pend[3:0]);
			key_scan_req = pend[4];
			timer_ovf_req = {<<{pend[9:5]}};
			sleep_exec = pend[10];
			serial_channel_one_req = pend[11];
			serial_channel_two_req = pend[12];
			adc_end_req = pend[13];
			@(negedge clk);
			set_lines(4'hf);
			{key_scan_req, timer_ovf_req, sleep_exec} = 0;
			{serial_channel_one_req, serial_channel_two_req, adc_end_req} = 0;
			repeat (8) @(negedge clk);
			while (pend != 0) begin
				i = 0;
				while (!pend[i])
					i++;
				unmask;
				wait_exc(VT[i], 0);
				chk("push", push_state, 1);
				pend[i] = 0;
				wr(i < 4 ? 16'hfff6 : i < 10 ? 16'hfff7 : 16'hfff8,
					~(8'h01 << BT[i]));
			end
		end
		// Outside reset with a request pending
		set_lines(4'he);
		repeat (3) @(negedge clk);
		set_lines(4'hf);
		// Mask set again while the request waits: nothing is accepted
		unmask;
		mask_set = 1;
		@(negedge clk);
		mask_set = 0;
		for (i = 0; i < 8; i++) begin
			chk("masked", exc_start, 0);
			@(negedge clk);
		end
		do_reset = 1;
		wait_exc(16'h0000, 1);
		rd(16'hfff6, 8'hc0);
		chk("mask", global_mask, 1);
		test_done;
	end
endmodule // testbench
